// ### logic/xps_crosspoint_ctrl.sv
// control logic of a four by four crosspoint switch
// assumes: serialClock comes from the controller and may stop at any time;
// clk is a free running local clock; rst_n is asynchronous, active low
//
// What this block does
// - each output picks one of four inputs
// - mode level selects serial or strap config
// - serial data shifted in on rising edge
// - cascade data repeats stream, address decremented
// - cascade data changes on rising serial edge
// - cascade clocks copy serial clock, mode low
// - load high copies load register to config
// - one load cycle suffices; held load repeats
// - mode high freezes all serial side state
// - strap pins pick one of four maps
// - mode high drives cascade clocks low
// - load uses last complete frame addressed to this device only
`include "xps_defs.svh"
module xps_crosspoint_ctrl
    import xps_pkg::*;
#(
    parameter int LANES = `XPS_LANES
)
(
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [`XPS_RADDR_W-1:0] regAddr,
    input wire logic [`XPS_RDATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`XPS_RDATA_W-1:0] regRdata,
    // serial control link
    input wire logic serialClock,
    input wire logic serialData,
    input wire logic loadStrobe,
    input wire logic modePin,
    // strap pins
    input wire logic config_pick_high,
    input wire logic config_pick_low,
    // switched lanes
    input wire logic input_lane_1,
    input wire logic input_lane_2,
    input wire logic input_lane_3,
    input wire logic input_lane_4,
    output logic output_lane_1,
    output logic output_lane_2,
    output logic output_lane_3,
    output logic output_lane_4,
    // cascade toward the next device
    output logic column_cascade_data,
    output logic row_cascade_data,
    output logic column_cascade_clock,
    output logic row_cascade_clock,
    output logic buffered_clock_output
);

    // the lane mapping below is written for exactly four lanes
    if (LANES != `XPS_LANES)
    begin : gLaneCheck
        $error("xps_crosspoint_ctrl serves exactly four lanes");
    end

    // lower one address field of a frame, wrapping at zero
    function automatic xps_frame_t relayFrame(
        input xps_frame_t f,
        input logic isColumn
    );
        xps_frame_t r;
        r = f;
        if (isColumn)
        begin
            r[`XPS_COL_MSB:`XPS_COL_LSB] =
                f[`XPS_COL_MSB:`XPS_COL_LSB] - `XPS_AFLD_W'(1);
        end
        else
        begin
            r[`XPS_ROW_MSB:`XPS_ROW_LSB] =
                f[`XPS_ROW_MSB:`XPS_ROW_LSB] - `XPS_AFLD_W'(1);
        end
        return r;
    endfunction

    // one 4:1 selector for a given output index
    function automatic logic pickLane(
        input xps_map_t m,
        input int unsigned outIdx,
        input logic [`XPS_LANES-1:0] lanes
    );
        logic [`XPS_PICK_W-1:0] idx;
        idx = m[outIdx*`XPS_PICK_W +: `XPS_PICK_W];
        return lanes[idx];
    endfunction

    // strap code to lane map
    function automatic xps_map_t strapMap(input xps_strap_t s);
        xps_map_t m;
        case (s)
            XPS_STRAP_DIST1: m = `XPS_MAP_DIST1;
            XPS_STRAP_DIST2: m = `XPS_MAP_DIST2;
            XPS_STRAP_REDUN: m = `XPS_MAP_REDUN;
            XPS_STRAP_BROAD: m = `XPS_MAP_BROAD;
            default: m = `XPS_MAP_BROAD;
        endcase
        return m;
    endfunction

    // serial clock domain state
    xps_frame_t shift_q, shift_d; // input shift path
    logic [`XPS_BITCNT_W-1:0] bitCnt_q, bitCnt_d; // position in frame
    xps_map_t loadReg_q, loadReg_d; // last accepted frame
    xps_map_t cfgReg_q, cfgReg_d; // serial configuration
    xps_frame_t colTx_q, colTx_d; // column cascade out path
    xps_frame_t rowTx_q, rowTx_d; // row cascade out path
    logic loadTgl_q, loadTgl_d; // flips on every config transfer
    xps_frame_t frameIn; // word if this bit closes a frame

    // serial side next state
    always_comb
    begin
        frameIn = {shift_q[`XPS_FRAME_W-2:0], serialData};
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        loadReg_d = loadReg_q;
        cfgReg_d = cfgReg_q;
        colTx_d = colTx_q;
        rowTx_d = rowTx_q;
        loadTgl_d = loadTgl_q;
        // with mode high the registers simply hold, as if unclocked
        if (!modePin)
        begin
            shift_d = frameIn;
            bitCnt_d = bitCnt_q + `XPS_BITCNT_W'(1);
            // cascade paths move one bit per rising edge
            colTx_d = {colTx_q[`XPS_FRAME_W-2:0], 1'b0};
            rowTx_d = {rowTx_q[`XPS_FRAME_W-2:0], 1'b0};
            if (bitCnt_q == `XPS_LAST_BIT)
            begin
                // whole frame in: relay it with one address lowered
                colTx_d = relayFrame(frameIn, 1'b1);
                rowTx_d = relayFrame(frameIn, 1'b0);
                // only frames addressed to this device are kept
                if (frameIn[`XPS_COL_MSB:`XPS_ROW_LSB] == '0)
                begin
                    loadReg_d = frameIn[`XPS_MAP_W-1:0];
                end
            end
            // load copies on every edge it stays high
            if (loadStrobe)
            begin
                cfgReg_d = loadReg_q;
                loadTgl_d = ~loadTgl_q;
                // load also realigns the frame counter
                bitCnt_d = '0;
                // settings go out on both cascades for readback
                colTx_d = xps_frame_t'(loadReg_q);
                rowTx_d = xps_frame_t'(loadReg_q);
            end
        end
    end

    // serial side registers; reset is asynchronous to this clock too
    always_ff @(posedge serialClock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_q <= '0;
            bitCnt_q <= '0;
            loadReg_q <= `XPS_MAP_RST;
            cfgReg_q <= `XPS_MAP_RST;
            colTx_q <= '0;
            rowTx_q <= '0;
            loadTgl_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            loadReg_q <= loadReg_d;
            cfgReg_q <= cfgReg_d;
            colTx_q <= colTx_d;
            rowTx_q <= rowTx_d;
            loadTgl_q <= loadTgl_d;
        end
    end

    // cascade data straight from the out path flops
    assign column_cascade_data = colTx_q[`XPS_FRAME_W-1];
    assign row_cascade_data = rowTx_q[`XPS_FRAME_W-1];

    // buffered clocks, forced low with mode high
    // a plain gate: the controller changes mode only with the clock low
    assign column_cascade_clock = serialClock & ~modePin;
    assign row_cascade_clock = serialClock & ~modePin;
    assign buffered_clock_output = serialClock & ~modePin;

    // local clock domain state
    logic tglSync1_q, tglSync2_q, tglSeen_q; // transfer toggle crossing
    logic modeSync1_q, modeSync2_q; // mode pin synchroniser
    logic [1:0] pickSync1_q, pickSync2_q; // strap pin synchroniser
    xps_map_t cfgCopy_q, cfgCopy_d; // serial config, local copy
    xps_map_t actMap_q, actMap_d; // map steering the selectors
    logic [`XPS_CTRL_EN_W-1:0] laneEn_q, laneEn_d; // output enables
    logic [`XPS_LOADS_W-1:0] loads_q, loads_d; // transfers seen
    logic [`XPS_RDATA_W-1:0] rdata_q, rdata_d; // read answer
    logic tglNew; // a transfer crossed over this cycle

    // synchronisers; first stages feed only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tglSync1_q <= 1'b0;
            tglSync2_q <= 1'b0;
            modeSync1_q <= 1'b0;
            modeSync2_q <= 1'b0;
            pickSync1_q <= '0;
            pickSync2_q <= '0;
        end
        else
        begin
            tglSync1_q <= loadTgl_q;
            tglSync2_q <= tglSync1_q;
            modeSync1_q <= modePin;
            modeSync2_q <= modeSync1_q;
            pickSync1_q <= {config_pick_high, config_pick_low};
            pickSync2_q <= pickSync1_q;
        end
    end

    // local next state: config copy, active map, registers
    always_comb
    begin
        tglNew = tglSync2_q != tglSeen_q;
        cfgCopy_d = cfgCopy_q;
        loads_d = loads_q;
        // cfgReg_q is still by the time the toggle has crossed,
        // unless load is held on past the edge on which a frame closes
        if (tglNew)
        begin
            cfgCopy_d = cfgReg_q;
            loads_d = loads_q + `XPS_LOADS_W'(1);
        end
        // mode level picks the source of the map
        if (modeSync2_q)
        begin
            actMap_d = strapMap(xps_strap_t'(pickSync2_q));
        end
        else
        begin
            actMap_d = cfgCopy_q;
        end
        // register writes
        laneEn_d = laneEn_q;
        if (regWrite && regAddr == `XPS_REG_CTRL)
        begin
            laneEn_d = regWdata[`XPS_CTRL_EN_W-1:0];
        end
        // read answer stands only in the cycle after the strobe
        rdata_d = '0;
        if (regRead)
        begin
            case (regAddr)
                `XPS_REG_CTRL:
                    rdata_d = `XPS_RDATA_W'(laneEn_q);
                `XPS_REG_STATUS:
                    rdata_d = `XPS_RDATA_W'({pickSync2_q, modeSync2_q,
                        actMap_q});
                `XPS_REG_LOADS:
                    rdata_d = `XPS_RDATA_W'(loads_q);
                // unmapped offsets read as zero
                default:
                    rdata_d = '0;
            endcase
        end
    end

    // local registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tglSeen_q <= 1'b0;
            cfgCopy_q <= `XPS_MAP_RST;
            actMap_q <= `XPS_MAP_RST;
            laneEn_q <= `XPS_CTRL_RST;
            loads_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            tglSeen_q <= tglSync2_q;
            cfgCopy_q <= cfgCopy_d;
            actMap_q <= actMap_d;
            laneEn_q <= laneEn_d;
            loads_q <= loads_d;
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    // four selectors sharing one set of inputs; all four switch together
    // because they read the single map register
    // the lanes stay a plain path: registering them would add latency
    logic [`XPS_LANES-1:0] lanesIn; // shared inputs
    assign lanesIn = {input_lane_4, input_lane_3, input_lane_2,
        input_lane_1};
    assign output_lane_1 = laneEn_q[0] &
        pickLane(actMap_q, 0, lanesIn);
    assign output_lane_2 = laneEn_q[1] &
        pickLane(actMap_q, 1, lanesIn);
    assign output_lane_3 = laneEn_q[2] &
        pickLane(actMap_q, 2, lanesIn);
    assign output_lane_4 = laneEn_q[3] &
        pickLane(actMap_q, 3, lanesIn);

endmodule

// ### logic/xps_defs.svh
// constants for the crosspoint switch control block
// assumes: included by bare name from the package and the design module
`ifndef XPS_DEFS_SVH
`define XPS_DEFS_SVH

// lane count and serial frame geometry
`define XPS_LANES 4
`define XPS_FRAME_W 16
`define XPS_BITCNT_W 4
`define XPS_LAST_BIT 4'hf
`define XPS_COL_MSB 15
`define XPS_COL_LSB 12
`define XPS_ROW_MSB 11
`define XPS_ROW_LSB 8
`define XPS_AFLD_W 4
`define XPS_MAP_W 8
`define XPS_PICK_W 2

// register port: offsets, widths, reset values
`define XPS_RADDR_W 4
`define XPS_RDATA_W 32
`define XPS_REG_CTRL 4'h0
`define XPS_REG_STATUS 4'h4
`define XPS_REG_LOADS 4'h8
`define XPS_CTRL_EN_W 4
`define XPS_CTRL_RST 4'hf
`define XPS_LOADS_W 8

// lane maps, two bits per output, output 1 in the low bits
`define XPS_MAP_DIST1 8'h00
`define XPS_MAP_DIST2 8'h55
`define XPS_MAP_REDUN 8'ha0
`define XPS_MAP_BROAD 8'he4
`define XPS_MAP_RST 8'he4

`endif

// ### logic/xps_pkg.sv
// types shared by the crosspoint switch control block
// assumes: xps_defs.svh is on the include path
package xps_pkg;
`include "xps_defs.svh"

    // code on the two strap pins, high pin first
    typedef enum logic [1:0]
    {
        XPS_STRAP_DIST1 = 2'h0,
        XPS_STRAP_DIST2 = 2'h1,
        XPS_STRAP_REDUN = 2'h2,
        XPS_STRAP_BROAD = 2'h3
    } xps_strap_t;

    // one lane index per output, packed
    typedef logic [`XPS_MAP_W-1:0] xps_map_t;

    // one serial frame
    typedef logic [`XPS_FRAME_W-1:0] xps_frame_t;

endpackage

// ### test/xps_crosspoint_ctrl_asserts.sv
// concurrent checks on the pins of the crosspoint switch control block
// assumes: bound into every instance of xps_crosspoint_ctrl
`include "xps_defs.svh"
module xps_crosspoint_ctrl_asserts
    import xps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`XPS_RADDR_W-1:0] regAddr,
    input wire logic regRead,
    input wire logic [`XPS_RDATA_W-1:0] regRdata,
    input wire logic serialClock,
    input wire logic loadStrobe,
    input wire logic modePin,
    input wire logic column_cascade_data,
    input wire logic row_cascade_data,
    input wire logic column_cascade_clock,
    input wire logic row_cascade_clock,
    input wire logic buffered_clock_output
);
    timeunit 1ns;
    timeprecision 100ps;
    // cascade clocks are the link clock gated by mode
    a_col_clk_copy: assert property (
        @(posedge clk) disable iff (!rst_n)
        column_cascade_clock == (serialClock & ~modePin))
        else $error("column cascade clock not a gated link clock");
    a_row_clk_copy: assert property (
        @(posedge clk) disable iff (!rst_n)
        row_cascade_clock == (serialClock & ~modePin))
        else $error("row cascade clock not a gated link clock");
    a_buf_clk_copy: assert property (
        @(posedge clk) disable iff (!rst_n)
        buffered_clock_output == (serialClock & ~modePin))
        else $error("buffered clock not a gated link clock");
    a_mode_clk_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        modePin |-> !column_cascade_clock && !row_cascade_clock)
        else $error("cascade clock high in strap mode");
    // read data stands only in the cycle after a read strobe
    a_read_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        !$past(regRead) |-> regRdata == '0)
        else $error("read data present without a read");
    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        regRead && regAddr == 4'hc |=> regRdata == '0)
        else $error("unmapped read returned data");
    // strap mode keeps the serial side frozen
    a_mode_freeze: assert property (
        @(posedge serialClock) disable iff (!rst_n)
        modePin && $past(modePin) |->
            $stable(column_cascade_data) && $stable(row_cascade_data))
        else $error("cascade data moved in strap mode");
    a_load_readback: assert property (
        @(posedge serialClock) disable iff (!rst_n)
        loadStrobe && !modePin |=> !column_cascade_data && !row_cascade_data)
        else $error("readback word does not start with zero");
    // data moves only right after a rising link edge
    a_cascade_on_rise: assert property (
        @(posedge clk) disable iff (!rst_n)
        $changed(column_cascade_data) || $changed(row_cascade_data)
            |-> $rose(serialClock))
        else $error("cascade data changed off a rising link edge");
endmodule

bind xps_crosspoint_ctrl xps_crosspoint_ctrl_asserts chk_u (
    .clk(clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regRead(regRead),
    .regRdata(regRdata),
    .serialClock(serialClock),
    .loadStrobe(loadStrobe),
    .modePin(modePin),
    .column_cascade_data(column_cascade_data),
    .row_cascade_data(row_cascade_data),
    .column_cascade_clock(column_cascade_clock),
    .row_cascade_clock(row_cascade_clock),
    .buffered_clock_output(buffered_clock_output)
);

// ### test/xps_link_host.sv
// behavioural controller at the far end of the serial link
// assumes: its tasks are called one at a time from the bench top
`include "xps_defs.svh"
module xps_link_host
    import xps_pkg::*;
(
    output logic serialClock,
    output logic serialData,
    output logic loadStrobe,
    input wire logic colIn,
    input wire logic rowIn
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 32; // half of the 64 ns link period

    // link clock rests low between bursts
    initial
    begin
        serialClock = 1'b0;
        serialData = 1'b1;
        loadStrobe = 1'b0;
    end

    // one whole frame, msb first; cascade pins read before each edge
    task automatic send_frame(input xps_frame_t f, output xps_frame_t cs,
        output xps_frame_t rs);
        #7;
        for (int i = `XPS_FRAME_W - 1; i >= 0; i--)
        begin
            serialData = f[i];
            cs[i] = colIn;
            rs[i] = rowIn;
            #(HALF) serialClock = 1'b1;
            #(HALF) serialClock = 1'b0;
        end
        // released line shows the inverse, not a stale bit
        serialData = ~f[0];
    endtask

    // load held high across the given number of rising edges
    task automatic pulse_load(input int edges);
        #7 loadStrobe = 1'b1;
        repeat (edges)
        begin
            #(HALF) serialClock = 1'b1;
            #(HALF) serialClock = 1'b0;
        end
        loadStrobe = 1'b0;
    endtask
endmodule

// ### test/test_crosspoint_switch_control.sv
// self-checking bench for the crosspoint switch control block
// assumes: xps_link_host plays the controller on the serial link
`include "xps_defs.svh"
module test_crosspoint_switch_control
    import xps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic modePin = 1'b0, pickHigh = 1'b0, pickLow = 1'b0;
    logic [3:0] regAddr = 4'h0, laneIn = 4'h0;
    logic [31:0] regWdata = 32'h0, rd;
    wire logic [31:0] regRdata;
    wire logic [3:0] laneOut;
    wire logic sClk, sData, loadStb, colData, rowData;
    int failCount = 0, totalChecks = 0;
    xps_frame_t cs, rs;

    always #10 clk = ~clk;

    xps_crosspoint_ctrl dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .serialClock(sClk), .serialData(sData),
        .loadStrobe(loadStb), .modePin(modePin),
        .config_pick_high(pickHigh), .config_pick_low(pickLow),
        .input_lane_1(laneIn[0]), .input_lane_2(laneIn[1]),
        .input_lane_3(laneIn[2]), .input_lane_4(laneIn[3]),
        .output_lane_1(laneOut[0]), .output_lane_2(laneOut[1]),
        .output_lane_3(laneOut[2]), .output_lane_4(laneOut[3]),
        .column_cascade_data(colData), .row_cascade_data(rowData),
        .column_cascade_clock(), .row_cascade_clock(),
        .buffered_clock_output());
    xps_link_host host_u (.serialClock(sClk), .serialData(sData),
        .loadStrobe(loadStb), .colIn(colData), .rowIn(rowData));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // walk a single one over the inputs, predict each output
    task automatic check_map(input xps_map_t m, input logic [3:0] en);
        logic [3:0] pat;
        logic [3:0] exp;
        for (int p = 0; p < 4; p++)
        begin
            pat = 4'h1 << p;
            @(posedge clk);
            laneIn <= pat;
            @(negedge clk);
            for (int k = 0; k < 4; k++)
                exp[k] = pat[m[2*k +: 2]] & en[k];
            check({28'h0, laneOut}, {28'h0, exp});
        end
    endtask
    task automatic closeOut();
        $display("checks %0d errors %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // strap codes in turn, then a frozen serial attempt
    task automatic t_strap();
        xps_map_t maps [4] = '{8'h00, 8'h55, 8'ha0, 8'he4};
        @(posedge clk);
        modePin <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clk);
            {pickHigh, pickLow} <= 2'(c);
            repeat (6) @(posedge clk);
            check_map(maps[c], 4'hf);
            reg_rd(`XPS_REG_STATUS, rd);
            check(rd, {21'h0, 2'(c), 1'b1, maps[c]});
        end
        host_u.send_frame(16'h001b, cs, rs);
        host_u.pulse_load(1);
        @(posedge clk);
        modePin <= 1'b0;
        repeat (6) @(posedge clk);
        check_map(`XPS_MAP_RST, 4'hf);
        reg_rd(`XPS_REG_LOADS, rd);
        check(rd, 32'h0);
    endtask
    // double buffered load, cascade decrement and readback
    task automatic t_serial();
        host_u.send_frame(16'h001b, cs, rs);
        repeat (8) @(posedge clk);
        check_map(`XPS_MAP_RST, 4'hf);
        host_u.pulse_load(1);
        repeat (8) @(posedge clk);
        check_map(8'h1b, 4'hf);
        host_u.send_frame(16'h124e, cs, rs);
        check({16'h0, cs}, 32'h001b);
        check({16'h0, rs}, 32'h001b);
        host_u.send_frame(16'h3300, cs, rs);
        check({16'h0, cs}, 32'h024e);
        check({16'h0, rs}, 32'h114e);
        host_u.pulse_load(2);
        repeat (8) @(posedge clk);
        check_map(8'h1b, 4'hf);
        reg_rd(`XPS_REG_LOADS, rd);
        check(rd, 32'h3);
    endtask
    // lane enables and an unmapped place
    task automatic t_regs();
        reg_wr(`XPS_REG_CTRL, 32'h5);
        repeat (2) @(posedge clk);
        check_map(8'h1b, 4'h5);
        reg_wr(4'hc, 32'hf);
        reg_rd(4'hc, rd);
        check(rd, 32'h0);
        reg_rd(`XPS_REG_CTRL, rd);
        check(rd, 32'h5);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check_map(`XPS_MAP_RST, 4'hf);
        reg_rd(`XPS_REG_CTRL, rd);
        check(rd, 32'hf);
        t_strap();
        t_serial();
        t_regs();
        closeOut();
    end
    // the whole run needs well under a tenth of this
    initial
    begin
        #100us;
        failCount++;
        closeOut();
    end
endmodule
